// [design/tt_clk_mod.sv]
// fixed-duty core clock gate used while the throttle modulates
`timescale 1ns/100ps
module tt_clk_mod
	import tt_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mod_en,
	output logic clk_gate
);
	logic [TT_MOD_CNT_W-1:0] cnt;

	// period counter runs on the fixed system clock, not the core ratio
	always_ff @(posedge clk) begin
		if (sys_rst || !mod_en) begin
			cnt <= '0;
		end else if (cnt == TT_MOD_CNT_W'(TT_MOD_PERIOD_CYC - 1)) begin
			cnt <= '0;
		end else begin
			cnt <= TT_MOD_CNT_W'(cnt + 1'b1);
		end
	end

	// on for the first quarter, off for the rest; the ratio is hard wired
	always_ff @(posedge clk) begin
		if (sys_rst || !mod_en) begin
			clk_gate <= 1'b1;
		end else begin
			clk_gate <= (cnt < TT_MOD_CNT_W'(TT_MOD_ON_CYC));
		end
	end

	chk_mod_period_wrap:
	assert property (@(posedge clk) disable iff (sys_rst)
		(mod_en && cnt == TT_MOD_CNT_W'(TT_MOD_PERIOD_CYC - 1)) ##1 mod_en
		|-> cnt == '0)
		else $error("modulation period not 32 us");
	chk_mod_off_quarter:
	assert property (@(posedge clk) disable iff (sys_rst)
		(mod_en && cnt == TT_MOD_CNT_W'(TT_MOD_ON_CYC)) ##1 mod_en
		|-> !clk_gate)
		else $error("clock still on after first quarter");
	chk_mod_on_start:
	assert property (@(posedge clk) disable iff (sys_rst)
		(mod_en && cnt == '0) ##1 mod_en |-> clk_gate)
		else $error("clock not on at period start");
endmodule // tt_clk_mod

// [design/tt_thermal_throttle.sv]
// adaptive thermal throttle: activation, operating point, status registers
`timescale 1ns/100ps
module tt_thermal_throttle
	import tt_pkg::*;
#(
	parameter int HYST_CYCLES = TT_HYST_DEFAULT,
	parameter int AVG_SAMPLE_CYCLES = TT_AVG_WINDOW_CYC / TT_AVG_SAMPLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [TT_NCORES-1:0][TT_RD_W-1:0] sensor_reading,
	input wire logic [TT_RD_W-1:0] thr1_reading,
	input wire logic [TT_RD_W-1:0] thr2_reading,
	input wire logic pstate_req_valid,
	input wire logic [TT_LVL_W-1:0] pstate_req_level,
	input wire tt_msr_req_type msr_req,
	output tt_msr_rsp_type msr_rsp,
	output logic [TT_LVL_W-1:0] freq_level,
	output logic [TT_LVL_W-1:0] volt_level,
	output logic exec_halt,
	output logic core_clk_en,
	output logic tcc_active,
	output logic mod_active,
	output logic thr_irq,
	output logic snoop_irq_en,
	output logic [TT_RD_W-1:0] sb_temp
);
	// builds a status word; used for core and package reads
	function automatic logic [63:0] tt_status_word(
		input logic active,
		input logic log_bit,
		input logic [TT_RD_W-1:0] rd,
		input logic [3:0] thr,
		input logic modul,
		input logic defer
	);
		logic [63:0] w;
		w = '0;
		w[TT_ST_ACTIVE] = active;
		w[TT_ST_LOG] = log_bit;
		w[TT_ST_THR1] = thr[0];
		w[TT_ST_THR1_LOG] = thr[1];
		w[TT_ST_THR2] = thr[2];
		w[TT_ST_THR2_LOG] = thr[3];
		w[TT_ST_MOD] = modul;
		w[TT_ST_DEFER] = defer;
		w[TT_ST_RD_LSB +: TT_RD_W] = rd;
		return w;
	endfunction

	logic [5:0] act_ofs;
	logic [TT_NCORES-1:0] hot_core;
	logic [TT_NCORES-1:0] core_log;
	logic any_hot;
	logic [TT_RD_W-1:0] pkg_reading;
	logic [TT_HYST_W-1:0] hyst_cnt;
	logic [TT_LVL_W-1:0] therm_lvl;
	logic [TT_LVL_W-1:0] req_lvl;
	logic [TT_LVL_W-1:0] target_lvl;
	logic [TT_LVL_W-1:0] goal_lvl;
	logic [TT_TIMER_W-1:0] step_cnt;
	logic [TT_TIMER_W-1:0] trans_cnt;
	logic trans_done;
	tt_op_state_type op_state;
	tt_op_state_type next_op_state;
	logic pkg_log;
	logic thr1_st;
	logic thr2_st;
	logic thr1_log;
	logic thr2_log;
	logic next_thr1;
	logic next_thr2;
	logic wr_core;
	logic wr_pkg;
	logic [TT_AVG_CNT_W-1:0] avg_cnt;
	logic [TT_AVG_IDX_W-1:0] avg_idx;
	logic [TT_AVG_SUM_W-1:0] avg_acc;
	logic [TT_AVG_SUM_W-1:0] avg_sum;
	logic mod_gate;

	// one comparator per core; the offset only moves the trip point, the
	// reading itself stays relative to the junction limit
	generate
		for (genvar i = 0; i < TT_NCORES; i++) begin : g_core
			assign hot_core[i] = sensor_reading[i] <= {1'b0, act_ofs};
			// sticky event log, a new event beats a software clear
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					core_log[i] <= 1'b0;
				end else if (hot_core[i]) begin
					core_log[i] <= 1'b1;
				end else if (wr_core && msr_req.core == TT_CORE_W'(i)
					&& !msr_req.wdata[TT_ST_LOG]) begin
					core_log[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// hottest core is the smallest offset below the limit
	always_comb begin
		pkg_reading = sensor_reading[0];
		for (int i = 1; i < TT_NCORES; i++) begin
			if (sensor_reading[i] < pkg_reading) begin
				pkg_reading = sensor_reading[i];
			end
		end
	end

	// there is deliberately no enable bit; only the trip point is tunable
	assign any_hot = |hot_core;
	assign wr_core = msr_req.wr && msr_req.addr == TT_ADDR_CORE_STAT;
	assign wr_pkg = msr_req.wr && msr_req.addr == TT_ADDR_PKG_STAT;

	// activation offset, the only writable part of the limit register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			act_ofs <= TT_OFS_RESET;
		end else if (msr_req.wr && msr_req.addr == TT_ADDR_LIMIT) begin
			act_ofs <= msr_req.wdata[TT_OFS_MSB:TT_OFS_LSB];
		end
	end

	// hysteresis timer reloads while hot, runs down once cool
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hyst_cnt <= '0;
		end else if (any_hot) begin
			hyst_cnt <= TT_HYST_W'(HYST_CYCLES);
		end else if (hyst_cnt != '0) begin
			hyst_cnt <= TT_HYST_W'(hyst_cnt - 1'b1);
		end
	end

	// throttle stays on until cool and the timer has run out
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tcc_active <= 1'b0;
		end else if (any_hot) begin
			tcc_active <= 1'b1;
		end else if (hyst_cnt == '0) begin
			tcc_active <= 1'b0;
		end
	end

	// thermal target walks down one level per step while still hot
	always_ff @(posedge clk) begin
		if (sys_rst || !tcc_active) begin
			therm_lvl <= TT_LVL_MAX;
			step_cnt <= '0;
		end else if (any_hot) begin
			if (step_cnt == TT_TIMER_W'(TT_STEP_CYC - 1)) begin
				step_cnt <= '0;
				if (therm_lvl != TT_LVL_MIN) begin
					therm_lvl <= TT_LVL_W'(therm_lvl - TT_LVL_STEP);
				end
			end else begin
				step_cnt <= TT_TIMER_W'(step_cnt + 1'b1);
			end
		end
	end

	// last software performance request is kept, even while deferred
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_lvl <= TT_LVL_MAX;
		end else if (pstate_req_valid) begin
			req_lvl <= pstate_req_level;
		end
	end

	// faster requests wait for the event to end, slower ones pass now
	assign target_lvl = (tcc_active && req_lvl > therm_lvl) ?
		therm_lvl : req_lvl;

	// sequencer: a rail change is given a fixed settle time
	assign trans_done = trans_cnt == TT_TIMER_W'(TT_TRANS_CYC - 1);
	always_comb begin
		next_op_state = op_state;
		case (op_state)
			TT_OP_IDLE: begin
				if (target_lvl > freq_level) begin
					next_op_state = TT_OP_VUP;
				end else if (target_lvl < freq_level) begin
					next_op_state = TT_OP_FDN;
				end
			end
			TT_OP_VUP: begin
				if (trans_done) next_op_state = TT_OP_FUP;
			end
			TT_OP_FUP: begin
				if (trans_done) next_op_state = TT_OP_IDLE;
			end
			TT_OP_FDN: begin
				if (trans_done) next_op_state = TT_OP_VDN;
			end
			TT_OP_VDN: begin
				if (trans_done) next_op_state = TT_OP_IDLE;
			end
			default: next_op_state = TT_OP_IDLE;
		endcase
	end

	// state, settle timer and latched goal of the running transition
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			op_state <= TT_OP_IDLE;
			trans_cnt <= '0;
			goal_lvl <= TT_LVL_MAX;
		end else begin
			op_state <= next_op_state;
			if (next_op_state != op_state) begin
				trans_cnt <= '0;
			end else if (op_state != TT_OP_IDLE) begin
				trans_cnt <= TT_TIMER_W'(trans_cnt + 1'b1);
			end
			if (op_state == TT_OP_IDLE) begin
				goal_lvl <= target_lvl;
			end
		end
	end

	// rails move on entry to their state; voltage leads up, trails down
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			freq_level <= TT_LVL_MAX;
			volt_level <= TT_LVL_MAX;
		end else begin
			if (op_state == TT_OP_VUP || op_state == TT_OP_VDN) begin
				volt_level <= goal_lvl;
			end
			if (op_state == TT_OP_FUP || op_state == TT_OP_FDN) begin
				freq_level <= goal_lvl;
			end
		end
	end

	// execution pauses only around frequency relock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			exec_halt <= 1'b0;
		end else begin
			exec_halt <= next_op_state == TT_OP_FUP
				|| next_op_state == TT_OP_FDN;
		end
	end

	// modulation only once frequency and voltage have run out of room;
	// it stops on the very edge that releases the throttle
	always_ff @(posedge clk) begin
		if (sys_rst || !tcc_active || (!any_hot && hyst_cnt == '0)) begin
			mod_active <= 1'b0;
		end else if (any_hot && therm_lvl == TT_LVL_MIN
			&& freq_level == TT_LVL_MIN && op_state == TT_OP_IDLE) begin
			mod_active <= 1'b1;
		end
	end

	tt_clk_mod u_clk_mod (
		.clk(clk),
		.sys_rst(sys_rst),
		.mod_en(mod_active),
		.clk_gate(mod_gate)
	);

	// gate and service enable registered; the gate stops execution
	// only, snoop and interrupt logic stays clocked
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			core_clk_en <= 1'b1;
			snoop_irq_en <= 1'b0;
		end else begin
			core_clk_en <= mod_gate;
			snoop_irq_en <= 1'b1;
		end
	end

	// threshold compare on the hottest reading; crossing either way logs
	assign next_thr1 = pkg_reading <= thr1_reading;
	assign next_thr2 = pkg_reading <= thr2_reading;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			thr1_st <= 1'b0;
			thr2_st <= 1'b0;
			thr_irq <= 1'b0;
		end else begin
			thr1_st <= next_thr1;
			thr2_st <= next_thr2;
			thr_irq <= (next_thr1 != thr1_st)
				|| (next_thr2 != thr2_st);
		end
	end

	// package sticky logs, set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pkg_log <= 1'b0;
			thr1_log <= 1'b0;
			thr2_log <= 1'b0;
		end else begin
			if (any_hot) pkg_log <= 1'b1;
			else if (wr_pkg && !msr_req.wdata[TT_ST_LOG]) pkg_log <= 1'b0;
			if (next_thr1 != thr1_st) thr1_log <= 1'b1;
			else if (wr_pkg && !msr_req.wdata[TT_ST_THR1_LOG]) thr1_log <= 1'b0;
			if (next_thr2 != thr2_st) thr2_log <= 1'b1;
			else if (wr_pkg && !msr_req.wdata[TT_ST_THR2_LOG]) thr2_log <= 1'b0;
		end
	end

	// block average of the hottest reading; a sliding window would need
	// a 256-entry store for little gain in a fan loop
	assign avg_sum = TT_AVG_SUM_W'(avg_acc + pkg_reading);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avg_cnt <= '0;
			avg_idx <= '0;
			avg_acc <= '0;
			sb_temp <= '0;
		end else if (avg_cnt == TT_AVG_CNT_W'(AVG_SAMPLE_CYCLES - 1)) begin
			avg_cnt <= '0;
			avg_idx <= TT_AVG_IDX_W'(avg_idx + 1'b1);
			if (avg_idx == TT_AVG_IDX_W'(TT_AVG_SAMPLES - 1)) begin
				avg_acc <= '0;
				sb_temp <= avg_sum[TT_AVG_SUM_W-1:TT_AVG_IDX_W];
			end else begin
				avg_acc <= avg_sum;
			end
		end else begin
			avg_cnt <= TT_AVG_CNT_W'(avg_cnt + 1'b1);
		end
	end

	// register answer one cycle after any access; unknown address errs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			msr_rsp <= '0;
		end else begin
			msr_rsp.ack <= msr_req.rd || msr_req.wr;
			msr_rsp.err <= (msr_req.rd || msr_req.wr)
				&& msr_req.addr != TT_ADDR_CORE_STAT
				&& msr_req.addr != TT_ADDR_LIMIT
				&& msr_req.addr != TT_ADDR_PKG_STAT;
			msr_rsp.rdata <= '0;
			if (msr_req.rd && msr_req.addr == TT_ADDR_CORE_STAT) begin
				msr_rsp.rdata <= tt_status_word(hot_core[msr_req.core],
					core_log[msr_req.core], sensor_reading[msr_req.core],
					4'h0, mod_active, 1'b0);
			end else if (msr_req.rd && msr_req.addr == TT_ADDR_PKG_STAT) begin
				msr_rsp.rdata <= tt_status_word(any_hot, pkg_log, pkg_reading,
					{thr2_log, thr2_st, thr1_log, thr1_st}, mod_active,
					tcc_active && req_lvl > therm_lvl);
			end else if (msr_req.rd && msr_req.addr == TT_ADDR_LIMIT) begin
				msr_rsp.rdata[TT_TJ_MSB:TT_TJ_LSB] <= TT_TJMAX_DEFAULT;
				msr_rsp.rdata[TT_OFS_MSB:TT_OFS_LSB] <= act_ofs;
			end
		end
	end

	chk_act_on_hot:
	assert property (@(posedge clk) disable iff (sys_rst)
		any_hot |=> tcc_active)
		else $error("hot sensor did not activate throttle");
	chk_zero_trips:
	assert property (@(posedge clk) disable iff (sys_rst)
		(act_ofs == TT_OFS_RESET && sensor_reading[0] == '0)
		|=> tcc_active && core_log[0])
		else $error("zero reading did not trip");
	chk_tj_fixed:
	assert property (@(posedge clk) disable iff (sys_rst)
		$past(msr_req.rd && msr_req.addr == TT_ADDR_LIMIT)
		|-> msr_rsp.rdata[TT_TJ_MSB:TT_TJ_LSB] == TT_TJMAX_DEFAULT)
		else $error("junction limit field changed");
	chk_step_down:
	assert property (@(posedge clk) disable iff (sys_rst)
		(tcc_active && any_hot && therm_lvl != TT_LVL_MIN
		&& step_cnt == TT_TIMER_W'(TT_STEP_CYC - 1))
		|=> therm_lvl == TT_LVL_W'($past(therm_lvl) - TT_LVL_STEP))
		else $error("thermal target did not step down");
	chk_volt_leads:
	assert property (@(posedge clk) disable iff (sys_rst)
		(op_state == TT_OP_FUP) |-> volt_level == goal_lvl)
		else $error("frequency rose before voltage");
	chk_freq_leads:
	assert property (@(posedge clk) disable iff (sys_rst)
		(op_state == TT_OP_VDN) |-> freq_level == goal_lvl)
		else $error("voltage fell before frequency");
	chk_halt_freq:
	assert property (@(posedge clk) disable iff (sys_rst)
		exec_halt |-> (op_state == TT_OP_FUP || op_state == TT_OP_FDN))
		else $error("halt outside frequency change");
	chk_defer_fast:
	assert property (@(posedge clk) disable iff (sys_rst)
		tcc_active |-> target_lvl <= therm_lvl && target_lvl <= req_lvl)
		else $error("faster request not deferred");
	chk_mod_min:
	assert property (@(posedge clk) disable iff (sys_rst)
		$rose(mod_active) |-> $past(therm_lvl) == TT_LVL_MIN
		&& $past(freq_level) == TT_LVL_MIN)
		else $error("modulation before minimum point");
	chk_release_hyst:
	assert property (@(posedge clk) disable iff (sys_rst)
		$fell(tcc_active) |-> $past(!any_hot) && $past(hyst_cnt) == '0
		&& !mod_active)
		else $error("throttle released early");
	chk_hyst_reload:
	assert property (@(posedge clk) disable iff (sys_rst)
		any_hot |=> hyst_cnt == TT_HYST_W'(HYST_CYCLES))
		else $error("hysteresis did not restart");
	chk_normal_back:
	assert property (@(posedge clk) disable iff (sys_rst)
		!tcc_active |-> target_lvl == req_lvl)
		else $error("not back to requested point");
	chk_service_on:
	assert property (@(posedge clk) disable iff (sys_rst)
		tcc_active |-> snoop_irq_en)
		else $error("service stopped while throttling");
	chk_thr_irq:
	assert property (@(posedge clk) disable iff (sys_rst)
		(next_thr1 != thr1_st) |=> thr_irq && thr1_log)
		else $error("threshold crossing not signalled");
endmodule // tt_thermal_throttle

// [pkg/tt_pkg.sv]
// shared constants, states and carriers for the adaptive thermal throttle
package tt_pkg;
	// core count and sensor readout width
	localparam int TT_NCORES = 2;
	localparam int TT_CORE_W = 1;
	localparam int TT_RD_W = 7;
	// model-specific register addresses
	localparam logic [31:0] TT_ADDR_CORE_STAT = 32'h0000_019c;
	localparam logic [31:0] TT_ADDR_LIMIT = 32'h0000_01a2;
	localparam logic [31:0] TT_ADDR_PKG_STAT = 32'h0000_01b1;
	// status word layout, shared by core and package status
	localparam int TT_ST_ACTIVE = 0;
	localparam int TT_ST_LOG = 1;
	localparam int TT_ST_THR1 = 6;
	localparam int TT_ST_THR1_LOG = 7;
	localparam int TT_ST_THR2 = 8;
	localparam int TT_ST_THR2_LOG = 9;
	localparam int TT_ST_MOD = 12;
	localparam int TT_ST_DEFER = 13;
	localparam int TT_ST_RD_LSB = 16;
	// limit register layout
	localparam int TT_TJ_LSB = 16;
	localparam int TT_TJ_MSB = 23;
	localparam int TT_OFS_LSB = 24;
	localparam int TT_OFS_MSB = 29;
	localparam logic [5:0] TT_OFS_RESET = 6'h00;
	// factory junction limit in degrees celsius
	localparam logic [7:0] TT_TJMAX_DEFAULT = 8'h69;
	// operating point levels, higher is faster
	localparam int TT_LVL_W = 4;
	localparam logic [3:0] TT_LVL_MIN = 4'h0;
	localparam logic [3:0] TT_LVL_MAX = 4'hf;
	localparam logic [3:0] TT_LVL_STEP = 4'h1;
	// timing
	localparam int TT_CLK_KHZ = 125000;
	localparam int TT_MOD_PERIOD_NS = 32000;
	// scaled in two steps so the product stays inside a 32-bit int
	localparam int TT_MOD_PERIOD_CYC = TT_MOD_PERIOD_NS * (TT_CLK_KHZ / 1000) / 1000;
	localparam int TT_MOD_ON_CYC = TT_MOD_PERIOD_CYC / 4;
	localparam int TT_MOD_CNT_W = 12;
	localparam int TT_AVG_WINDOW_MS = 256;
	localparam int TT_AVG_WINDOW_CYC = TT_AVG_WINDOW_MS * TT_CLK_KHZ;
	localparam int TT_AVG_SAMPLES = 256;
	localparam int TT_AVG_CNT_W = 17;
	localparam int TT_AVG_IDX_W = 8;
	localparam int TT_AVG_SUM_W = 15;
	localparam int TT_TRANS_CYC = 8;
	localparam int TT_STEP_CYC = 64;
	localparam int TT_TIMER_W = 8;
	localparam int TT_HYST_W = 16;
	localparam int TT_HYST_DEFAULT = 1000;
	// one-hot operating point sequencer
	typedef enum logic [4:0] {
		TT_OP_IDLE = 5'b0_0001,
		TT_OP_VUP = 5'b0_0010,
		TT_OP_FUP = 5'b0_0100,
		TT_OP_FDN = 5'b0_1000,
		TT_OP_VDN = 5'b1_0000
	} tt_op_state_type;
	// register access request and answer
	typedef struct packed {
		logic rd;
		logic wr;
		logic [31:0] addr;
		logic [TT_CORE_W-1:0] core;
		logic [63:0] wdata;
	} tt_msr_req_type;
	typedef struct packed {
		logic ack;
		logic err;
		logic [63:0] rdata;
	} tt_msr_rsp_type;
endpackage

// [verif/tb_top.sv]
// self-checking bench for the adaptive thermal throttle
`timescale 1ns/100ps
module tb_top;
	import tt_pkg::*;
	localparam int HYST = 20;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [TT_NCORES-1:0][TT_RD_W-1:0] sensor_reading;
	logic [TT_RD_W-1:0] thr1_reading = 7'h14;
	logic [TT_RD_W-1:0] thr2_reading = 7'h0a;
	logic pstate_req_valid = 1'b0;
	logic [TT_LVL_W-1:0] pstate_req_level = 4'hf;
	tt_msr_req_type msr_req = '0;
	tt_msr_rsp_type msr_rsp;
	logic [TT_LVL_W-1:0] freq_level, volt_level, prev_freq = 4'hf;
	logic exec_halt, core_clk_en, tcc_active, mod_active, thr_irq;
	logic snoop_irq_en;
	logic [TT_RD_W-1:0] sb_temp, polled_temp;
	logic [63:0] rd;
	logic er;
	int errors = 0;
	int total_checks = 0;
	int i;

	tt_thermal_throttle #(.HYST_CYCLES(HYST), .AVG_SAMPLE_CYCLES(4))
		tt_thermal_throttle_inst (.clk(clk), .sys_rst(sys_rst),
		.sensor_reading(sensor_reading), .thr1_reading(thr1_reading),
		.thr2_reading(thr2_reading), .pstate_req_valid(pstate_req_valid),
		.pstate_req_level(pstate_req_level), .msr_req(msr_req),
		.msr_rsp(msr_rsp), .freq_level(freq_level),
		.volt_level(volt_level), .exec_halt(exec_halt),
		.core_clk_en(core_clk_en), .tcc_active(tcc_active),
		.mod_active(mod_active), .thr_irq(thr_irq),
		.snoop_irq_en(snoop_irq_en), .sb_temp(sb_temp));
	tt_sb_poller tt_sb_poller_inst (.clk(clk), .sys_rst(sys_rst),
		.sb_temp(sb_temp), .polled_temp(polled_temp), .poll_count());

	always #4 clk = ~clk;

	task automatic check(input logic [63:0] seen, exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic report_and_stop;
		if (errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic temp(input logic [6:0] a, b);
		sensor_reading[0] = a;
		sensor_reading[1] = b;
	endtask

	// one register access; ack lands one edge after the request edge
	task automatic msr(input logic w, input logic [31:0] a, input logic c,
		input logic [63:0] d);
		msr_req.rd = !w;
		msr_req.wr = w;
		msr_req.addr = a;
		msr_req.core = c;
		msr_req.wdata = d;
		cyc(1);
		check(msr_rsp.ack, 1'b1, "missing ack");
		rd = msr_rsp.rdata;
		er = msr_rsp.err;
		msr_req.rd = 1'b0;
		msr_req.wr = 1'b0;
		cyc(1);
	endtask

	task automatic req(input logic [3:0] l);
		pstate_req_level = l;
		pstate_req_valid = 1'b1;
		cyc(1);
		pstate_req_valid = 1'b0;
	endtask

	task automatic t_sideband;
		cyc(2200);
		check(polled_temp, 7'h28, "sideband average");
	endtask

	task automatic t_thresholds;
		temp(7'h0f, 7'h28);
		for (i = 0; i < 4 && thr_irq !== 1'b1; i++) cyc(1);
		check(thr_irq, 1'b1, "first crossing");
		msr(0, TT_ADDR_PKG_STAT, 0, '0);
		check({rd[TT_ST_THR2], rd[TT_ST_THR1]}, 2'h1, "thr1 only");
		temp(7'h08, 7'h28);
		for (i = 0; i < 4 && thr_irq !== 1'b1; i++) cyc(1);
		check(thr_irq, 1'b1, "second crossing");
		msr(0, TT_ADDR_PKG_STAT, 0, '0);
		check({rd[TT_ST_THR2], rd[TT_ST_THR1]}, 2'h3, "both");
		temp(7'h28, 7'h28);
		cyc(4);
	endtask

	// offset moves the trip point; the junction field stays fixed
	task automatic t_limit;
		msr(0, TT_ADDR_LIMIT, 0, '0);
		check(rd[29:16], 14'h0069, "limit default");
		msr(1, TT_ADDR_LIMIT, 0, 64'h0000_0000_05ff_0000);
		msr(0, TT_ADDR_LIMIT, 0, '0);
		check(rd[29:16], 14'h0569, "offset write");
		temp(7'h06, 7'h28);
		cyc(10);
		check(tcc_active, 1'b0, "above offset point");
		temp(7'h05, 7'h28);
		cyc(3);
		check(tcc_active, 1'b1, "at offset point");
		temp(7'h28, 7'h28);
		cyc(HYST + 8);
		check(tcc_active, 1'b0, "stuck active");
		msr(1, TT_ADDR_LIMIT, 0, '0);
		msr(0, 32'h0000_0100, 0, '0);
		check(er, 1'b1, "unmapped error");
		check(rd, 64'h0, "unmapped data");
	endtask

	task automatic t_cores;
		temp(7'h1e, 7'h28);
		cyc(2);
		for (i = 0; i < 2; i++) begin
			msr(0, TT_ADDR_CORE_STAT, i[0], '0);
			check(rd[22:16], i ? 7'h28 : 7'h1e, "core read");
		end
		msr(0, TT_ADDR_PKG_STAT, 0, '0);
		check(rd[22:16], 7'h1e, "package reading");
	endtask

	task automatic t_throttle;
		int hi;
		int lo;
		temp(7'h00, 7'h14);
		cyc(3);
		check(tcc_active, 1'b1, "zero reading");
		msr(0, TT_ADDR_CORE_STAT, 0, '0);
		check(rd[1:0], 2'h3, "core hot flags");
		cyc(200);
		check(freq_level < 4'hf, 1'b1, "no slowdown");
		req(4'h2);
		for (i = 0; i < 60 && freq_level !== 4'h2; i++) cyc(1);
		check(freq_level, 4'h2, "slower request");
		req(4'hf);
		cyc(3);
		msr(0, TT_ADDR_PKG_STAT, 0, '0);
		check(rd[TT_ST_DEFER], 1'b1, "defer flag");
		for (i = 0; i < 3000 && mod_active !== 1'b1; i++) cyc(1);
		check({mod_active, freq_level}, {1'b1, TT_LVL_MIN}, "no mod");
		msr(0, TT_ADDR_CORE_STAT, 0, '0);
		check(rd[TT_ST_MOD], 1'b1, "mod status");
		for (i = 0; i < 4100 && core_clk_en !== 1'b0; i++) cyc(1);
		for (i = 0; i < 4100 && core_clk_en !== 1'b1; i++) cyc(1);
		for (hi = 0; hi < 5000 && core_clk_en === 1'b1; hi++) cyc(1);
		for (lo = 0; lo < 5000 && core_clk_en === 1'b0; lo++) cyc(1);
		check(hi, TT_MOD_ON_CYC, "on time");
		check(hi + lo, TT_MOD_PERIOD_CYC, "period");
		check(snoop_irq_en, 1'b1, "service gated");
		// a brief hot spell in mid-cooldown must restart the timer
		temp(7'h28, 7'h28);
		cyc(10);
		temp(7'h00, 7'h28);
		cyc(2);
		temp(7'h28, 7'h28);
		cyc(HYST - 2);
		check(tcc_active, 1'b1, "early release");
		for (i = 0; i < 8 && tcc_active !== 1'b0; i++) cyc(1);
		check({tcc_active, mod_active}, 2'h0, "no release");
		for (i = 0; i < 60 && freq_level !== 4'hf; i++) cyc(1);
		check(freq_level, 4'hf, "no return");
		msr(1, TT_ADDR_CORE_STAT, 0, '0);
		msr(0, TT_ADDR_CORE_STAT, 0, '0);
		check(rd[1:0], 2'h0, "log not cleared");
	endtask

	// frequency only moves while halted; voltage never lags below it
	always @(negedge clk) begin
		if (!sys_rst) begin
			check(volt_level >= freq_level, 1'b1, "volt order");
			if (freq_level !== prev_freq)
				check(exec_halt, 1'b1, "freq moved unhalted");
			prev_freq = freq_level;
		end
	end

	initial begin
		temp(7'h28, 7'h28);
		cyc(2);
		sys_rst = 1'b0;
		cyc(1);
		check({freq_level, volt_level, tcc_active, mod_active, core_clk_en,
			snoop_irq_en, exec_halt}, {8'hff, 5'b0_0110}, "reset");
		t_sideband;
		t_thresholds;
		t_limit;
		t_cores;
		t_throttle;
		report_and_stop;
	end

	// hang guard, well beyond the expected run length
	initial begin
		#600000;
		errors++;
		report_and_stop;
	end
endmodule // tb_top

// [verif/tt_sb_poller.sv]
// platform manager model that polls the averaged sideband temperature
`timescale 1ns/100ps
module tt_sb_poller
	import tt_pkg::*;
#(
	parameter int POLL_CYCLES = 64
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [TT_RD_W-1:0] sb_temp,
	output logic [TT_RD_W-1:0] polled_temp,
	output logic [15:0] poll_count
);
	logic [15:0] gap;

	// slow fixed-rate poll, as a fan controller would do it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gap <= 16'h0000;
			poll_count <= 16'h0000;
			polled_temp <= '0;
		end else if (gap == 16'(POLL_CYCLES - 1)) begin
			gap <= 16'h0000;
			poll_count <= poll_count + 16'h0001;
			polled_temp <= sb_temp;
		end else begin
			gap <= gap + 16'h0001;
		end
	end
endmodule // tt_sb_poller
